/* design/tsw_dev.sv */
// Sensor end of the two-wire link: address match, pointer and multi-device access.
//
// Behaviour
// - host opens with START, SDA falls, SCL high.
// - host closes with STOP, SDA rises, SCL high.
// - address byte sampled on rising SCL, LSB direction.
// - ninth clock acknowledges only a matching address.
// - every byte gets a ninth acknowledge clock.
// - SDA changes while SCL high mean START/STOP.
// - own address is 1110 plus three variant bits.
// - host sends pointer first in every write.
// - read without pointer uses last written pointer.
// - new register needs write, pointer, repeated START.
// - all bytes travel most significant bit first.
// - acknowledge shared addresses 00h write, 01h read.
// - shared write acknowledges pointer, stores data byte.
// - shared read returns one byte per device, ordered.
// - host NACK stops all later shared slots.
// - absent slots read ones; host clocks them all.
// - general call then 06h resets internal registers.
// - general call with other byte: 00h-03h acked as pointer, rest no ack.
// - two low pointer bits select register, upper zero.
// - SCL low about 30 ms resets the interface.
// - high-speed code not acknowledged, mode until STOP.
// - pointer resets to temperature register.
`timescale 1ns/10ps
`default_nettype none

module tsw_dev
    import tsw_pkg::*;
#(
    parameter logic [2:0] ADDR_VARIANT = 3'h0,
    parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC
) (
    // Clock, reset and enable
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    // Two-wire link
    tsw_if.dev LINK,
    // Register file side
    output logic [1:0] PTR_O,
    output logic WR_STB_O,
    output logic [7:0] WR_DATA_O,
    input wire logic [7:0] RD_DATA_I,
    output logic RD_STB_O,
    output logic GC_RST_O,
    output logic HS_MODE_O
);
    localparam int unsigned TW = $clog2(TIMEOUT_CYCLES + 1);

    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_RACK} tsw_dev_st_t;
    typedef enum logic [1:0] {RL_ADDR, RL_PTR, RL_DATA, RL_DONE} tsw_dev_role_t;

    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic scl_f;
        logic sda_f;
        tsw_dev_st_t st;
        tsw_dev_role_t role;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic rd;
        logic mda;
        logic mine;
        logic hs;
        logic [2:0] slot;
        logic [1:0] ptr;
        logic sda_low;
        logic wr_stb;
        logic [7:0] wr_data;
        logic rd_stb;
        logic gc_rst;
        logic [TW-1:0] tmo;
    } tsw_dev_state_t;

    tsw_dev_state_t q;
    tsw_dev_state_t d;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic [7:0] b;

    always_comb
    begin
        d = q;
        d.wr_stb = 1'b0;
        d.rd_stb = 1'b0;
        d.gc_rst = 1'b0;
        // Three-stage sampling; a level is taken once stages two and three agree.
        d.scl_s = {q.scl_s[1:0], LINK.scl};
        d.sda_s = {q.sda_s[1:0], LINK.sda};
        if (q.scl_s[2] == q.scl_s[1])
        begin
            d.scl_f = q.scl_s[1];
        end
        if (q.sda_s[2] == q.sda_s[1])
        begin
            d.sda_f = q.sda_s[1];
        end
        rise = d.scl_f & ~q.scl_f;
        fall = ~d.scl_f & q.scl_f;
        start = d.scl_f & q.scl_f & q.sda_f & ~d.sda_f;
        stop = d.scl_f & q.scl_f & ~q.sda_f & d.sda_f;
        b = q.sh;

        if (q.st == ST_IDLE || d.scl_f)
        begin
            d.tmo = '0;
        end
        else
        begin
            d.tmo = q.tmo + 1'b1;
        end

        case (q.st)
            ST_RX:
            begin
                if (rise)
                begin
                    d.sh = {q.sh[6:0], d.sda_f};
                    d.cnt = q.cnt + 4'h1;
                end
                else if (fall && q.cnt == BYTE_BITS)
                begin
                    d.cnt = '0;
                    d.st = ST_IDLE;
                    case (q.role)
                        RL_ADDR:
                        begin
                            d.rd = b[0];
                            d.mda = (b == MDA_WR_ADDR) || (b == MDA_RD_ADDR);
                            d.slot = '0;
                            if (b[7:3] == HS_CODE)
                            begin
                                d.hs = 1'b1;
                            end
                            else if (b[7:1] == {ADDR_BASE, ADDR_VARIANT} || d.mda)
                            begin
                                d.sda_low = 1'b1;
                                d.st = ST_ACK;
                                d.role = RL_PTR;
                            end
                        end
                        RL_PTR:
                        begin
                            d.role = RL_DATA;
                            if (q.mda && b == GC_RESET_CODE)
                            begin
                                // General call reset also returns the pointer.
                                d.gc_rst = 1'b1;
                                d.ptr = PTR_RESET;
                                d.sda_low = 1'b1;
                                d.st = ST_ACK;
                                d.role = RL_DONE;
                            end
                            else if (!q.mda || b[7:2] == 6'h00)
                            begin
                                d.ptr = b[1:0];
                                d.sda_low = 1'b1;
                                d.st = ST_ACK;
                            end
                        end
                        RL_DATA:
                        begin
                            d.wr_stb = 1'b1;
                            d.wr_data = b;
                            d.sda_low = 1'b1;
                            d.st = ST_ACK;
                        end
                        default:
                        begin
                            d.st = ST_IDLE;
                        end
                    endcase
                end
            end
            ST_ACK:
            begin
                if (fall)
                begin
                    d.sda_low = 1'b0;
                    d.st = ST_RX;
                    if (q.rd)
                    begin
                        // Load on the falling edge so the first bit is settled before SCL rises.
                        d.st = ST_TX;
                        d.cnt = '0;
                        d.mine = !q.mda || (q.slot == ADDR_VARIANT);
                        d.sh = RD_DATA_I;
                        d.sda_low = d.mine & ~RD_DATA_I[7];
                        d.rd_stb = d.mine;
                    end
                end
            end
            ST_TX:
            begin
                if (fall)
                begin
                    if (q.cnt == LAST_BIT)
                    begin
                        d.sda_low = 1'b0;
                        d.st = ST_RACK;
                    end
                    else
                    begin
                        d.sh = {q.sh[6:0], 1'b0};
                        d.cnt = q.cnt + 4'h1;
                        d.sda_low = q.mine & ~q.sh[6];
                    end
                end
            end
            ST_RACK:
            begin
                if (rise)
                begin
                    d.st = ST_IDLE;
                    // A released line here is a NACK and ends every later slot.
                    if (!d.sda_f && (!q.mda || q.slot < ADDR_VARIANT))
                    begin
                        d.slot = q.slot + 3'h1;
                        d.st = ST_ACK;
                    end
                end
            end
            default:
            begin
                d.st = ST_IDLE;
            end
        endcase

        if (start)
        begin
            d.st = ST_RX;
            d.role = RL_ADDR;
            d.cnt = '0;
            d.sda_low = 1'b0;
        end
        if (stop)
        begin
            d.st = ST_IDLE;
            d.sda_low = 1'b0;
            d.hs = 1'b0;
        end
        if (q.tmo >= TW'(TIMEOUT_CYCLES - 1))
        begin
            d.st = ST_IDLE;
            d.sda_low = 1'b0;
            d.tmo = '0;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            q <= '0;
            q.scl_s <= 3'h7;
            q.sda_s <= 3'h7;
            q.scl_f <= 1'b1;
            q.sda_f <= 1'b1;
            q.ptr <= PTR_RESET;
        end
        else if (CE_I)
        begin
            q <= d;
        end
    end

    assign LINK.dev_sda_o = 1'b0;
    assign LINK.dev_sda_oe_n = ~q.sda_low;
    assign PTR_O = q.ptr;
    assign WR_STB_O = q.wr_stb;
    assign WR_DATA_O = q.wr_data;
    assign RD_STB_O = q.rd_stb;
    assign GC_RST_O = q.gc_rst;
    assign HS_MODE_O = q.hs;
endmodule // tsw_dev

`default_nettype wire

/* design/tsw_fifo.sv */
// Parameterised valid/ready FIFO.
`timescale 1ns/10ps
`default_nettype none

module tsw_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    // Clock, reset and enable
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } tsw_fifo_state_t;

    tsw_fifo_state_t q;
    tsw_fifo_state_t d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign in_ready_o = (q.wr[AW] == q.rd[AW]) || (q.wr[AW-1:0] != q.rd[AW-1:0]);
    assign out_valid_o = q.wr != q.rd;
    assign out_data_o = mem[q.rd[AW-1:0]];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    always_comb
    begin
        d = q;
        if (push)
        begin
            d.wr = q.wr + 1'b1;
        end
        if (pop)
        begin
            d.rd = q.rd + 1'b1;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            q <= '0;
        end
        else if (CE_I)
        begin
            q <= d;
        end
    end

    // Storage needs no reset; only the pointers say what is valid.
    always_ff @(posedge CLK_I)
    begin
        if (CE_I && push)
        begin
            mem[q.wr[AW-1:0]] <= in_data_i;
        end
    end
endmodule // tsw_fifo

`default_nettype wire

/* design/tsw_host.sv */
// Host end of the two-wire link: runs queued commands as bus transactions.
`timescale 1ns/10ps
`default_nettype none

module tsw_host
    import tsw_pkg::*;
#(
    parameter int unsigned QTR_CYCLES = SCL_QTR_CYC,
    parameter int unsigned DEPTH = FIFO_DEPTH
) (
    // Clock, reset and enable
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    // Two-wire link
    tsw_if.host LINK,
    // Command queue
    input wire logic CMD_VALID_I,
    output logic CMD_READY_O,
    input wire tsw_cmd_t CMD_I,
    // Results
    output logic RD_VALID_O,
    output logic [7:0] RD_DATA_O,
    output logic NACK_O,
    output logic BUSY_O
);
    localparam int unsigned DW = $clog2(QTR_CYCLES + 1);

    typedef enum logic [2:0] {TK_START, TK_WR, TK_RD_ACK, TK_RD_NACK, TK_STOP, TK_END} tsw_tok_kind_t;
    typedef struct packed {
        tsw_tok_kind_t k;
        logic [7:0] b;
    } tsw_tok_t;

    typedef struct packed {
        logic [2:0] sda_s;
        logic sda_f;
        logic [DW-1:0] div;
        logic [1:0] ph;
        logic [3:0] bitn;
        logic [3:0] step;
        tsw_cmd_t cmd;
        logic busy;
        logic abort;
        logic [7:0] sh;
        logic scl_low;
        logic sda_low;
        logic rd_valid;
        logic [7:0] rd_data;
        logic nack;
    } tsw_host_state_t;

    tsw_host_state_t q;
    tsw_host_state_t d;
    tsw_tok_t t;
    logic pop_valid;
    tsw_cmd_t pop_cmd;

    // Byte sequence of each command; pointer follows the write address in every command but the plain read and the general call reset.
    function automatic tsw_tok_t tok(input tsw_cmd_t c, input logic [3:0] s);
        logic [7:0] aw;
        logic [7:0] ar;
        logic [3:0] last;
        tsw_tok_t r;
        aw = {ADDR_BASE, c.variant, 1'b0};
        ar = {ADDR_BASE, c.variant, 1'b1};
        last = MDA_SLOT0_STEP + {1'b0, c.data[2:0]};
        r = '{TK_END, 8'h00};
        if (s == 4'h0)
        begin
            r = '{TK_START, 8'h00};
        end
        else
        begin
            case (c.kind)
                CMD_WRITE, CMD_MDA_WRITE:
                begin
                    if (s == 4'h1)
                    begin
                        r = '{TK_WR, (c.kind == CMD_WRITE) ? aw : MDA_WR_ADDR};
                    end
                    else if (s == 4'h2)
                    begin
                        r = '{TK_WR, c.ptr};
                    end
                    else if (s == 4'h3)
                    begin
                        r = '{TK_WR, c.data};
                    end
                    else if (s == 4'h4)
                    begin
                        r = '{TK_STOP, 8'h00};
                    end
                end
                CMD_READ:
                begin
                    r = (s == 4'h1) ? '{TK_WR, ar} : (s == 4'h2) ? '{TK_RD_NACK, 8'h00} :
                        (s == 4'h3) ? '{TK_STOP, 8'h00} : '{TK_END, 8'h00};
                end
                CMD_PTR_READ, CMD_MDA_READ:
                begin
                    // Write address, pointer, repeated START, then the read address.
                    case (s)
                        4'h1: r = '{TK_WR, (c.kind == CMD_PTR_READ) ? aw : MDA_WR_ADDR};
                        4'h2: r = '{TK_WR, c.ptr};
                        4'h3: r = '{TK_START, 8'h00};
                        4'h4: r = '{TK_WR, (c.kind == CMD_PTR_READ) ? ar : MDA_RD_ADDR};
                        default:
                        begin
                            if (c.kind == CMD_PTR_READ)
                            begin
                                r = (s == 4'h5) ? '{TK_RD_NACK, 8'h00} :
                                    (s == 4'h6) ? '{TK_STOP, 8'h00} : '{TK_END, 8'h00};
                            end
                            else if (s < last)
                            begin
                                r = '{TK_RD_ACK, 8'h00};
                            end
                            else
                            begin
                                r = (s == last) ? '{TK_RD_NACK, 8'h00} :
                                    (s == last + 4'h1) ? '{TK_STOP, 8'h00} : '{TK_END, 8'h00};
                            end
                        end
                    endcase
                end
                CMD_GC_RESET:
                begin
                    r = (s == 4'h1) ? '{TK_WR, MDA_WR_ADDR} : (s == 4'h2) ? '{TK_WR, GC_RESET_CODE} :
                        (s == 4'h3) ? '{TK_STOP, 8'h00} : '{TK_END, 8'h00};
                end
                default:
                begin
                    r = '{TK_END, 8'h00};
                end
            endcase
        end
        return r;
    endfunction

    tsw_fifo #(
        .WIDTH(CMD_W),
        .DEPTH(DEPTH)
    ) u_cmd_fifo (
        .CLK_I(CLK_I),
        .RST_N_I(RST_N_I),
        .CE_I(CE_I),
        .in_valid_i(CMD_VALID_I),
        .in_ready_o(CMD_READY_O),
        .in_data_i(CMD_I),
        .out_valid_o(pop_valid),
        .out_ready_i(~q.busy),
        .out_data_o(pop_cmd)
    );

    always_comb
    begin
        d = q;
        d.rd_valid = 1'b0;
        d.nack = 1'b0;
        d.sda_s = {q.sda_s[1:0], LINK.sda};
        if (q.sda_s[2] == q.sda_s[1])
        begin
            d.sda_f = q.sda_s[1];
        end
        t = tok(q.cmd, q.step);
        if (q.abort && t.k != TK_END)
        begin
            t.k = TK_STOP;
        end
        if (!q.busy)
        begin
            if (pop_valid)
            begin
                d.cmd = pop_cmd;
                d.busy = 1'b1;
                d.step = '0;
                d.ph = '0;
                d.bitn = '0;
                d.div = '0;
                d.abort = 1'b0;
            end
        end
        else if (t.k == TK_END)
        begin
            d.busy = 1'b0;
        end
        else if (q.div != DW'(QTR_CYCLES - 1))
        begin
            d.div = q.div + 1'b1;
        end
        else
        begin
            d.div = '0;
            d.ph = q.ph + 2'h1;
            case (t.k)
                TK_START:
                begin
                    // Release SDA first so a repeated START sees it high under high SCL.
                    d.sda_low = (q.ph >= 2'h2);
                    d.scl_low = (q.ph == 2'h3);
                end
                TK_STOP:
                begin
                    d.scl_low = (q.ph == 2'h0);
                    d.sda_low = (q.ph <= 2'h1);
                end
                default:
                begin
                    if (q.ph == 2'h0)
                    begin
                        // SDA moves only in the low half of SCL.
                        if (q.bitn == BYTE_BITS)
                        begin
                            d.sda_low = (t.k == TK_RD_ACK);
                        end
                        else
                        begin
                            d.sda_low = (t.k == TK_WR) & ~t.b[3'(LAST_BIT - q.bitn)];
                        end
                    end
                    d.scl_low = (q.ph == 2'h3) || (q.ph == 2'h0);
                    if (q.ph == 2'h2)
                    begin
                        if (q.bitn != BYTE_BITS)
                        begin
                            d.sh = {q.sh[6:0], d.sda_f};
                        end
                        else if (t.k == TK_WR && d.sda_f)
                        begin
                            d.nack = 1'b1;
                            d.abort = 1'b1;
                        end
                    end
                end
            endcase
            if (q.ph == 2'h3)
            begin
                if (t.k == TK_START || t.k == TK_STOP || q.bitn == BYTE_BITS)
                begin
                    d.step = q.step + 4'h1;
                    d.bitn = '0;
                    d.rd_valid = (t.k == TK_RD_ACK) || (t.k == TK_RD_NACK);
                    d.rd_data = q.sh;
                end
                else
                begin
                    d.bitn = q.bitn + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            q <= '0;
            q.sda_s <= 3'h7;
            q.sda_f <= 1'b1;
        end
        else if (CE_I)
        begin
            q <= d;
        end
    end

    assign LINK.host_scl_o = 1'b0;
    assign LINK.host_scl_oe_n = ~q.scl_low;
    assign LINK.host_sda_o = 1'b0;
    assign LINK.host_sda_oe_n = ~q.sda_low;
    assign RD_VALID_O = q.rd_valid;
    assign RD_DATA_O = q.rd_data;
    assign NACK_O = q.nack;
    assign BUSY_O = q.busy;
endmodule // tsw_host

`default_nettype wire

/* design/tsw_if.sv */
// Open-drain two-wire link joining the host end and the sensor end.
`timescale 1ns/10ps
`default_nettype none

interface tsw_if;
    logic host_scl_o;
    logic host_scl_oe_n;
    logic host_sda_o;
    logic host_sda_oe_n;
    logic dev_sda_o;
    logic dev_sda_oe_n;
    logic scl;
    logic sda;

    // Pull-ups hold each wire high unless an enabled driver pulls it low.
    assign scl = host_scl_oe_n | host_scl_o;
    assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

    modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
    modport host (input scl, input sda, output host_scl_o, output host_scl_oe_n,
                  output host_sda_o, output host_sda_oe_n);
endinterface // tsw_if

`default_nettype wire

/* design/tsw_pkg.sv */
// Shared constants and types for the two-wire temperature sensor link.
package tsw_pkg;

    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned TIMEOUT_MS = 30;
    localparam int unsigned TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MS;
    localparam int unsigned SCL_HZ = 400_000;
    localparam int unsigned SCL_QTR_CYC = CLK_HZ / (SCL_HZ * 4);
    localparam int unsigned FIFO_DEPTH = 16;

    localparam logic [3:0] ADDR_BASE = 4'he;
    localparam logic [7:0] MDA_WR_ADDR = 8'h00;
    localparam logic [7:0] MDA_RD_ADDR = 8'h01;
    localparam logic [7:0] GC_RESET_CODE = 8'h06;
    localparam logic [4:0] HS_CODE = 5'h01;
    localparam logic [1:0] PTR_RESET = 2'h0;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] MDA_SLOT0_STEP = 4'h5;

    typedef enum logic [2:0] {
        CMD_WRITE,
        CMD_READ,
        CMD_PTR_READ,
        CMD_MDA_WRITE,
        CMD_MDA_READ,
        CMD_GC_RESET
    } tsw_cmd_kind_t;

    typedef struct packed {
        tsw_cmd_kind_t kind;
        logic [2:0] variant;
        logic [7:0] ptr;
        logic [7:0] data;
    } tsw_cmd_t;

    localparam int unsigned CMD_W = $bits(tsw_cmd_t);

endpackage

/* sim/temp_sensor_two_wire_slave_mda_tb_top.sv */
// Testbench joining host and sensor ends, checked against a queue-based reference.
`timescale 1ns/10ps
`default_nettype none

module temp_sensor_two_wire_slave_mda_tb_top;
    import tsw_pkg::*;
    localparam logic [2:0] VAR = 3'h2;
    logic CLK_I = 1'b0;
    logic RST_N_I = 1'b0;
    logic cmd_valid = 1'b0;
    tsw_cmd_t cmd = '0;
    logic cmd_ready, rd_valid, nack, busy, wr_stb;
    logic rd_stb, gc_rst, hs_mode;
    int rd_stbs = 0;
    int gc_rsts = 0;
    int hs_seen = 0;
    logic [7:0] rd_data, wr_data;
    logic [1:0] ptr;
    logic [7:0] tbl [4] = '{8'h3c, 8'ha5, 8'h5a, 8'hc3};
    logic [7:0] exp_rd [$];
    logic [7:0] exp_wr [$];
    int miscompares = 0;
    int compares = 0;
    int nacks = 0;
    int idle = 0;
    tsw_if lnk ();
    always #4 CLK_I = ~CLK_I;

    tsw_host #(.QTR_CYCLES(8)) tsw_host_inst (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .CE_I(1'b1),
        .LINK(lnk.host), .CMD_VALID_I(cmd_valid), .CMD_READY_O(cmd_ready), .CMD_I(cmd),
        .RD_VALID_O(rd_valid), .RD_DATA_O(rd_data), .NACK_O(nack), .BUSY_O(busy));
    tsw_dev #(.ADDR_VARIANT(VAR), .TIMEOUT_CYCLES(2000)) tsw_dev_inst (.CLK_I(CLK_I),
        .RST_N_I(RST_N_I), .CE_I(1'b1), .LINK(lnk.dev), .PTR_O(ptr), .WR_STB_O(wr_stb),
        .WR_DATA_O(wr_data), .RD_DATA_I(tbl[ptr]), .RD_STB_O(rd_stb), .GC_RST_O(gc_rst),
        .HS_MODE_O(hs_mode));
    tsw_link_props tsw_link_props_inst (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
        .host_scl_o(lnk.host_scl_o), .host_scl_oe_n(lnk.host_scl_oe_n),
        .host_sda_o(lnk.host_sda_o), .host_sda_oe_n(lnk.host_sda_oe_n),
        .dev_sda_o(lnk.dev_sda_o), .dev_sda_oe_n(lnk.dev_sda_oe_n), .scl(lnk.scl), .sda(lnk.sda));

    task automatic check(input logic [7:0] seen, input logic [7:0] expect_v);
        compares++;
        if (seen !== expect_v)
        begin
            miscompares++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, expect_v);
        end
    endtask

    task automatic conclude();
        if (miscompares == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // The queue never holds more than ten commands, so ready must already stand high.
    task automatic push(input tsw_cmd_kind_t k, input logic [2:0] v, input logic [7:0] p,
                        input logic [7:0] d);
        @(posedge CLK_I);
        #1;
        cmd_valid = 1'b1;
        cmd = '{k, v, p, d};
        check({7'h0, cmd_ready}, 8'h01);
    endtask

    always @(posedge CLK_I)
    begin
        if (rd_valid) check(rd_data, exp_rd.pop_front());
        if (wr_stb) check(wr_data, exp_wr.pop_front());
        if (nack) nacks++;
        if (rd_stb === 1'b1) rd_stbs++;
        if (gc_rst === 1'b1) gc_rsts++;
        if (hs_mode !== 1'b0) hs_seen++;
    end

    initial
    begin
        logic [7:0] d;
        void'($urandom(51));
        repeat (12) @(posedge CLK_I);
        #1 RST_N_I = 1'b1;
        repeat (4) @(posedge CLK_I);
        d = 8'($urandom);
        push(CMD_WRITE, VAR, 8'h01, d);
        exp_wr.push_back(d);
        push(CMD_READ, VAR, 8'h00, 8'h00);
        exp_rd.push_back(tbl[1]);
        push(CMD_PTR_READ, VAR, 8'h03, 8'h00);
        exp_rd.push_back(tbl[3]);
        push(CMD_READ, VAR, 8'h00, 8'h00);
        exp_rd.push_back(tbl[3]);
        d = 8'($urandom);
        push(CMD_MDA_WRITE, 3'h0, 8'h02, d);
        exp_wr.push_back(d);
        push(CMD_MDA_READ, 3'h0, 8'h00, 8'h03);
        for (int s = 0; s < 4; s++)
            exp_rd.push_back((s == int'(VAR)) ? tbl[0] : 8'hff);
        push(CMD_PTR_READ, VAR, 8'h01, 8'h00);
        exp_rd.push_back(tbl[1]);
        push(CMD_GC_RESET, 3'h0, 8'h00, 8'h00);
        push(CMD_READ, VAR, 8'h00, 8'h00);
        exp_rd.push_back(tbl[0]);
        push(CMD_WRITE, VAR ^ 3'h5, 8'h01, 8'h00);
        @(posedge CLK_I);
        #1 cmd_valid = 1'b0;
        for (int i = 0; i < 60000 && idle < 300; i++)
        begin
            @(posedge CLK_I);
            idle = (busy === 1'b0) ? idle + 1 : 0;
        end
        if (idle < 300)
            miscompares++;
        check(8'(nacks), 8'h01);
        // Six reads load a byte here: one per plain or pointer read and only the own shared slot.
        check(8'(rd_stbs), 8'h06);
        check(8'(gc_rsts), 8'h01);
        check(8'(hs_seen), 8'h00);
        check(8'(exp_rd.size() + exp_wr.size()), 8'h00);
        conclude();
    end
endmodule // temp_sensor_two_wire_slave_mda_tb_top

`default_nettype wire

/* sim/tsw_link_props.sv */
// Wire-level checks on the two-wire link between host and sensor ends.
`timescale 1ns/10ps
`default_nettype none

module tsw_link_props (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_N_I,
    // Link signals
    input wire logic host_scl_o,
    input wire logic host_scl_oe_n,
    input wire logic host_sda_o,
    input wire logic host_sda_oe_n,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe_n,
    input wire logic scl,
    input wire logic sda
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    property p_pull_only; !dev_sda_o && !host_sda_o && !host_scl_o; endproperty
    property p_dev_steady; scl && $past(scl) |-> $stable(dev_sda_oe_n); endproperty
    property p_ack_low; $fell(dev_sda_oe_n) |-> !scl; endproperty
    property p_rel_low; $rose(dev_sda_oe_n) |-> !scl; endproperty
    property p_scl_high; $rose(scl) |-> scl [*8]; endproperty
    property p_scl_low; $fell(scl) |-> !scl [*8]; endproperty
    property p_stop_free; scl && $rose(sda) |=> dev_sda_oe_n [*8]; endproperty
    property p_start_quiet; scl && $fell(sda) |-> dev_sda_oe_n [*8]; endproperty
    a_pull_only: assert property (p_pull_only) else $error("line driven high");
    a_dev_steady: assert property (p_dev_steady) else $error("data moved, clock high");
    a_ack_low: assert property (p_ack_low) else $error("drive began, clock high");
    a_rel_low: assert property (p_rel_low) else $error("release, clock high");
    a_scl_high: assert property (p_scl_high) else $error("clock high too short");
    a_scl_low: assert property (p_scl_low) else $error("clock low too short");
    a_stop_free: assert property (p_stop_free) else $error("data held after stop");
    a_start_quiet: assert property (p_start_quiet) else $error("data held at start");
    c_start: cover property (scl && $fell(sda));
    c_ack: cover property ($fell(dev_sda_oe_n));
    c_stop: cover property (scl && $rose(sda));
endmodule // tsw_link_props

`default_nettype wire
